/* File: logic/btc_pkg.sv */
// Package: offsets, field positions, reset values and carriers of the terminal control registers
package btc_pkg;
	// ==========================================================
	// Register indices (printed offsets are word indices)
	localparam logic [4:0] BTC_IDX_IRQ_MASK = 5'h00;
	localparam logic [4:0] BTC_IDX_MODE = 5'h01;
	localparam logic [4:0] BTC_IDX_GCFG = 5'h02;
	localparam logic [4:0] BTC_IDX_CMD = 5'h03;
	localparam logic [4:0] BTC_IDX_MCW = 5'h04;
	localparam logic [4:0] BTC_IDX_IRQ_STAT = 5'h06;
	localparam logic [4:0] BTC_IDX_ENH = 5'h07;
	localparam int BTC_ADDR_W = 8;
	// ==========================================================
	// Field positions
	localparam int BTC_MODE_RT = 15;
	localparam int BTC_MODE_MT = 14;
	localparam int BTC_MODE_MMT = 12;
	localparam int BTC_GCFG_ENH_IRQ = 15;
	localparam int BTC_GCFG_PARITY = 14;
	localparam int BTC_GCFG_AUTOCLR = 4;
	localparam int BTC_GCFG_PULSE = 3;
	localparam int BTC_GCFG_TTR_LO = 7;
	localparam int BTC_ENH_EN = 15;
	localparam int BTC_ENH_ALT = 5;
	localparam int BTC_CMD_RESET = 0;
	localparam int BTC_CMD_START = 1;
	localparam int BTC_CMD_IRQRST = 2;
	localparam int BTC_CMD_TTRST = 3;
	localparam int BTC_CMD_TTCLK = 4;
	// Status bits of the interrupt register
	localparam int BTC_ST_EOM = 0;
	localparam int BTC_ST_BCEOM = 4;
	localparam int BTC_ST_EOF = 3;
	// ==========================================================
	// Reset values
	localparam logic [15:0] BTC_RST_MODE = 16'h0000;
	localparam logic [15:0] BTC_RST_GCFG = 16'h0000;
	localparam logic [15:0] BTC_RST_MCW = 16'h0000;
	localparam logic [15:0] BTC_RST_MASK = 16'h0000;
	localparam logic [15:0] BTC_RST_ENH = 16'h0000;
	// Read-only mode-register bits overlaid from engine state
	localparam logic [15:0] BTC_MODE_RO_BC = 16'h0007;
	localparam logic [15:0] BTC_MODE_RO_RT = 16'h0001;
	localparam logic [15:0] BTC_MODE_RO_MT = 16'h0007;
	// ==========================================================
	typedef enum logic [1:0] {
		BTC_FN_BC = 2'b00,
		BTC_FN_RT = 2'b10,
		BTC_FN_MT = 2'b01
	} btc_fn_e;
	// Engine status arriving from the protocol engine
	typedef struct packed {
		logic bc_enabled;
		logic frame_active;
		logic msg_active;
		logic rt_msg_active;
		logic mon_enabled;
		logic mon_triggered;
		logic mon_active;
		logic [15:0] cmd_stack_ptr;
	} btc_eng_s;
	// Command pulses toward the engine
	typedef struct packed {
		logic term_reset;
		logic start;
		logic irq_reset;
		logic tt_reset;
		logic tt_test_clk;
	} btc_cmd_s;
	// Decoded configuration toward the engine
	typedef struct packed {
		logic [1:0] fn;
		logic enhanced;
		logic mon_alongside;
		logic [15:0] mode_ctl;
		logic enh_irq;
		logic parity_en;
		logic busy_lut_en;
		logic rx_dbl_buf;
		logic ovwr_invalid;
		logic no_256_bound;
		logic [2:0] tt_res;
		logic tt_clr_sync;
		logic tt_load_sync;
		logic clr_srq;
		logic enh_rt_mm;
		logic sep_bcst;
		logic [15:0] mcw;
		logic tx_tt_sync;
	} btc_cfg_s;
endpackage : btc_pkg

/* File: logic/btc_irq.sv */
// Sticky interrupt status with mask, level or pulse request and auto clear
`timescale 1ns/100ps
`default_nettype none
module btc_irq
	import btc_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Events and software control
	input wire logic [15:0] events,
	input wire logic [15:0] w1c,
	input wire logic rd_clear,
	input wire logic reset_all,
	input wire logic [15:0] mask,
	input wire logic pulse_mode,
	// State
	output logic [15:0] status,
	output logic irq
);
	// ==========================================================
	// Sticky bits: a new event wins over any clear in the same cycle
	logic [15:0] next_status;
	logic pend;
	logic pend_d;
	always_comb
	begin
		next_status = status;
		if (reset_all || rd_clear)
		begin
			next_status = 16'h0000;
		end
		next_status = (next_status & ~w1c) | events;
	end
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			status <= 16'h0000;
		else
			status <= next_status;
	end
	// Level while pending, or one-cycle pulse on a new pending edge
	assign pend = |(status & mask);
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			pend_d <= 1'b0;
		else
			pend_d <= pend;
	end
	assign irq = pulse_mode ? (pend & ~pend_d) : pend;
endmodule : btc_irq
`default_nettype wire

/* File: logic/btc_regs.sv */
// Terminal control register bank behind an AXI4-Lite slave
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// [R1] Mode register bits 15 and 14 pick the function: 00 controller, 15 terminal, 14 monitor.
// [R2] In controller function bits 2..0 read back enabled, frame and message activity; 11..0 need enhanced mode.
// [R3] In monitor function bits 12..0 need enhanced mode; 11,10,9,7 control trigger use.
// [R4] In terminal function bit 0 reads message-in-progress, without alternate status only when enhanced.
// [R5] Bit 12 enables the monitor alongside the terminal; bits 11..7 hold terminal status controls.
// [R6] Configuration bit 15 enables enhanced interrupts and bit 14 RAM parity.
// [R7] Configuration bits 9..7 set the time tag resolution.
// [R8] Configuration bits 6 and 5 clear or load the time tag on a synchronize command.
// [R9] Configuration bit 4 auto-clears interrupt status, bit 3 picks level or pulse request.
// [R10] Configuration bits 13..10 control busy table, double buffering, overwrite and boundary.
// [R11] Configuration bits 2..0 clear service request, enhanced memory management, separate broadcast.
// [R12] Writes to offset 03H reset, start, reset interrupts, reset or clock the time tag.
// [R13] Offset 04H holds status masks, retry, bus channel, end-of-message interrupt and formats.
// [R14] Message control bit 15 makes the controller send its time tag as sync data.
// [R15] Reading offset 03H returns the 16-bit command stack pointer.
// [R16] Command bits are one-cycle pulses, unstored, and zeros do nothing.
module btc_regs
	import btc_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// AXI4-Lite write address and data
	input wire logic [BTC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [BTC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Protocol engine side
	input wire btc_eng_s eng,
	input wire logic [15:0] eng_events,
	output btc_cmd_s cmd,
	output btc_cfg_s cfg,
	// Interrupt request
	output logic irq
);
	// ==========================================================
	// Helpers
	function automatic logic [4:0] widx(input logic [BTC_ADDR_W-1:0] a);
		widx = a[6:2];
	endfunction : widx
	function automatic logic mapped(input logic [BTC_ADDR_W-1:0] a);
		mapped = (a[1:0] == 2'b00) && (a[BTC_ADDR_W-1] == 1'b0) &&
			(widx(a) <= BTC_IDX_ENH) && (widx(a) != 5'h05);
	endfunction : mapped
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
		input logic [3:0] s);
		merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge

	logic [15:0] mode_reg;
	logic [15:0] gcfg;
	logic [15:0] mcw;
	logic [15:0] mask;
	logic [15:0] enh;
	logic [15:0] status;
	logic [BTC_ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic aw_full;
	logic w_full;
	logic do_write;
	logic wr_ok;
	logic [4:0] wi;
	logic do_read;
	logic rd_clear;
	logic [15:0] w1c;
	logic [15:0] rd_val;
	btc_fn_e fn;
	logic enhanced;
	logic alt_status;

	// ==========================================================
	// Write channels: address and data are held until both are present
	assign s_axi_awready = !aw_full;
	assign s_axi_wready = !w_full;
	assign do_write = aw_full && w_full && !s_axi_bvalid;
	assign wi = widx(aw_addr);
	assign wr_ok = mapped(aw_addr);
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			aw_full <= 1'b0;
			aw_addr <= '0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_full <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
		else if (do_write)
			aw_full <= 1'b0;
	end
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			w_full <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_full <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		else if (do_write)
			w_full <= 1'b0;
	end
	// Response: unmapped addresses get SLVERR and change nothing
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// ==========================================================
	// Stored registers, written with byte lanes 0 and 1
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			mode_reg <= BTC_RST_MODE;
			gcfg <= BTC_RST_GCFG;
			mcw <= BTC_RST_MCW;
			mask <= BTC_RST_MASK;
			enh <= BTC_RST_ENH;
		end
		else if (do_write && wr_ok)
		begin
			unique case (wi)
				BTC_IDX_MODE: mode_reg <= merge(mode_reg, w_data[15:0], w_strb); // [R1] [R5]
				BTC_IDX_GCFG: gcfg <= merge(gcfg, w_data[15:0], w_strb); // [R6]
				BTC_IDX_MCW: mcw <= merge(mcw, w_data[15:0], w_strb); // [R13]
				BTC_IDX_IRQ_MASK: mask <= merge(mask, w_data[15:0], w_strb);
				BTC_IDX_ENH: enh <= merge(enh, w_data[15:0], w_strb);
				default: ;
			endcase
		end
	end

	// Command pulses live for exactly the write cycle; nothing is stored
	always_comb
	begin
		cmd = '0;
		if (do_write && wr_ok && (wi == BTC_IDX_CMD) && w_strb[0])
		begin
			cmd.term_reset = w_data[BTC_CMD_RESET]; // [R12] [R16]
			cmd.start = w_data[BTC_CMD_START]; // [R12]
			cmd.irq_reset = w_data[BTC_CMD_IRQRST]; // [R12]
			cmd.tt_reset = w_data[BTC_CMD_TTRST]; // [R12]
			cmd.tt_test_clk = w_data[BTC_CMD_TTCLK]; // [R12]
		end
	end
	// Write one to clear the interrupt status
	assign w1c = (do_write && wr_ok && (wi == BTC_IDX_IRQ_STAT)) ?
		merge(16'h0000, w_data[15:0], w_strb) : 16'h0000;

	// ==========================================================
	// Function decode and configuration toward the engine
	assign fn = btc_fn_e'(mode_reg[BTC_MODE_RT:BTC_MODE_MT]); // [R1]
	assign enhanced = enh[BTC_ENH_EN];
	assign alt_status = enh[BTC_ENH_ALT];
	always_comb
	begin
		cfg = '0;
		cfg.fn = mode_reg[BTC_MODE_RT:BTC_MODE_MT]; // [R1]
		cfg.enhanced = enhanced;
		cfg.mode_ctl = mode_reg;
		// Enhanced-only fields are hidden from the engine outside enhanced mode
		if (!enhanced && (fn == BTC_FN_BC))
			cfg.mode_ctl[11:0] = 12'h000; // [R2]
		if (!enhanced && (fn == BTC_FN_MT))
			cfg.mode_ctl[12:0] = 13'h0000; // [R3]
		if (!enhanced && (fn == BTC_FN_RT) && !alt_status)
			cfg.mode_ctl[7] = 1'b0; // [R5]
		cfg.mon_alongside = (fn == BTC_FN_RT) && mode_reg[BTC_MODE_MMT]; // [R5]
		cfg.enh_irq = gcfg[BTC_GCFG_ENH_IRQ]; // [R6]
		cfg.parity_en = gcfg[BTC_GCFG_PARITY]; // [R6]
		cfg.busy_lut_en = gcfg[13]; // [R10]
		cfg.rx_dbl_buf = gcfg[12]; // [R10]
		cfg.ovwr_invalid = gcfg[11]; // [R10]
		cfg.no_256_bound = gcfg[10]; // [R10]
		cfg.tt_res = gcfg[BTC_GCFG_TTR_LO+2:BTC_GCFG_TTR_LO]; // [R7]
		cfg.tt_clr_sync = gcfg[6]; // [R8]
		cfg.tt_load_sync = gcfg[5]; // [R8]
		cfg.clr_srq = gcfg[2]; // [R11]
		cfg.enh_rt_mm = gcfg[1]; // [R11]
		cfg.sep_bcst = gcfg[0]; // [R11]
		cfg.mcw = mcw; // [R13]
		cfg.tx_tt_sync = (fn == BTC_FN_BC) && mcw[15]; // [R14]
	end

	// ==========================================================
	// Mode register readback with engine state in the read-only bits
	always_comb
	begin
		rd_val = 16'h0000;
		unique case (fn)
			BTC_FN_BC:
			begin
				rd_val = (mode_reg & ~BTC_MODE_RO_BC) |
					{13'h0000, eng.bc_enabled, eng.frame_active, eng.msg_active}; // [R2]
				if (!enhanced)
					rd_val[11:0] = 12'h000; // [R2]
			end
			BTC_FN_MT:
			begin
				rd_val = (mode_reg & ~BTC_MODE_RO_MT) |
					{13'h0000, eng.mon_enabled, eng.mon_triggered, eng.mon_active}; // [R3]
				rd_val[8] = 1'b0;
				rd_val[6:3] = 4'h0;
				if (!enhanced)
					rd_val[12:0] = 13'h0000; // [R3]
			end
			default:
			begin
				// Terminal: bits 6..1 read back only with alternate status, bit 0 live activity unless neither alternate status nor enhanced
				rd_val = (mode_reg & ~BTC_MODE_RO_RT) | {15'h0000, eng.rt_msg_active}; // [R4]
				if (!alt_status)
					rd_val[6:1] = 6'h00;
				if (!alt_status && !enhanced)
				begin
					rd_val[0] = 1'b0; // [R4]
					rd_val[7] = 1'b0; // [R5]
				end
			end
		endcase
	end

	// ==========================================================
	// Read channel: one read in flight, answered one cycle after address
	assign s_axi_arready = !s_axi_rvalid;
	assign do_read = s_axi_arvalid && s_axi_arready;
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
		end
		else if (do_read)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
			s_axi_rdata <= 32'h00000000;
			if (mapped(s_axi_araddr))
			begin
				unique case (widx(s_axi_araddr))
					BTC_IDX_MODE: s_axi_rdata <= {16'h0000, rd_val};
					BTC_IDX_GCFG: s_axi_rdata <= {16'h0000, gcfg};
					BTC_IDX_CMD: s_axi_rdata <= {16'h0000, eng.cmd_stack_ptr}; // [R15]
					BTC_IDX_MCW: s_axi_rdata <= {16'h0000, mcw};
					BTC_IDX_IRQ_MASK: s_axi_rdata <= {16'h0000, mask};
					BTC_IDX_IRQ_STAT: s_axi_rdata <= {16'h0000, status};
					BTC_IDX_ENH: s_axi_rdata <= {16'h0000, enh};
					default: s_axi_rdata <= 32'h00000000;
				endcase
			end
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
	// Auto clear empties the status once software has read it
	assign rd_clear = do_read && gcfg[BTC_GCFG_AUTOCLR] && mapped(s_axi_araddr) &&
		(widx(s_axi_araddr) == BTC_IDX_IRQ_STAT); // [R9]

	// ==========================================================
	// Interrupt status, mask and request
	btc_irq u_irq (
		.clock(clock),
		.rstn(rstn),
		.events(eng_events),
		.w1c(w1c),
		.rd_clear(rd_clear),
		.reset_all(cmd.irq_reset),
		.mask(mask),
		.pulse_mode(gcfg[BTC_GCFG_PULSE]),
		.status(status),
		.irq(irq)
	);

	// ==========================================================
	// Checks
	a_cmd_pulse_once: assert property (@(posedge clock) disable iff (!rstn)
		cmd.start |=> !cmd.start) else $error("start pulse longer than one cycle"); // [R16]
	a_cmd_from_write: assert property (@(posedge clock) disable iff (!rstn)
		cmd.term_reset |-> (do_write && wi == BTC_IDX_CMD && w_data[0]))
		else $error("reset pulse without command write"); // [R12]
	a_fn_decode: assert property (@(posedge clock) disable iff (!rstn)
		cfg.fn == mode_reg[15:14]) else $error("function select mismatch"); // [R1]
	a_ttres_field: assert property (@(posedge clock) disable iff (!rstn)
		cfg.tt_res == gcfg[9:7]) else $error("time tag resolution wrong"); // [R7]
	a_ptr_readback: assert property (@(posedge clock) disable iff (!rstn)
		(do_read && s_axi_araddr == 8'h0c) |=> (s_axi_rvalid && s_axi_rdata[15:0] ==
		$past(eng.cmd_stack_ptr))) else $error("stack pointer readback wrong"); // [R15]
	a_bc_ro_bits: assert property (@(posedge clock) disable iff (!rstn)
		(do_read && s_axi_araddr == 8'h04 && fn == BTC_FN_BC && enhanced) |=>
		(s_axi_rdata[0] == $past(eng.msg_active))) else $error("bc activity bit wrong"); // [R2]
	a_tt_sync_bc: assert property (@(posedge clock) disable iff (!rstn)
		cfg.tx_tt_sync |-> (mcw[15] && fn == BTC_FN_BC)) else $error("sync tag flag wrong"); // [R14]
	a_autoclr_read: assert property (@(posedge clock) disable iff (!rstn)
		(rd_clear && eng_events == 16'h0000 && w1c == 16'h0000) |=> status == 16'h0000)
		else $error("status not cleared on read"); // [R9]
	a_mmt_enable: assert property (@(posedge clock) disable iff (!rstn)
		cfg.mon_alongside |-> (mode_reg[12] && fn == BTC_FN_RT))
		else $error("monitor alongside wrong"); // [R5]
endmodule : btc_regs
`default_nettype wire

/* File: bench/btc_eng_model.sv */
// Behavioural protocol engine that answers the register bank's start and terminal reset commands
`timescale 1ns/100ps
`default_nettype none
module btc_eng_model
	import btc_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Register bank side
	input wire btc_cmd_s cmd,
	output btc_eng_s eng,
	// Activity and stack pointer chosen by the bench
	input wire logic [4:0] act,
	input wire logic [15:0] ptr
);
	logic running;
	// ==========================================================
	// Start raises the enables; terminal reset wins over a start
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			running <= 1'b0;
		else if (cmd.term_reset)
			running <= 1'b0;
		else if (cmd.start)
			running <= 1'b1;
	end
	// Activity flags are bare levels, no message traffic behind them
	assign eng = '{bc_enabled: running, frame_active: act[4], msg_active: act[3],
		rt_msg_active: act[2], mon_enabled: running, mon_triggered: act[1],
		mon_active: act[0], cmd_stack_ptr: ptr};
endmodule : btc_eng_model
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the terminal control register bank
`timescale 1ns/100ps
`default_nettype none
module testbench
	import btc_pkg::*;
;
	logic clock, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [15:0] eng_events, ptr, d;
	logic [4:0] act;
	logic [1:0] fn;
	logic [7:0] bad [4] = '{8'h14, 8'h05, 8'h84, 8'h20};
	btc_eng_s eng;
	btc_cmd_s cmd;
	btc_cfg_s cfg;
	int err_count, total_checks, seed, irq_cnt, ic;
	int pc [5];
	int c [5];
	// ==========================================================
	// Clock, design and engine model
	always #5 clock = ~clock;
	btc_regs dut (.clock, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .eng, .eng_events, .cmd, .cfg, .irq);
	btc_eng_model eng_model (.clock, .rstn, .cmd, .eng, .act, .ptr);
	// Pulse counters; a one-cycle pulse adds exactly one
	always @(posedge clock)
	begin
		irq_cnt += irq;
		pc[0] += cmd.term_reset;
		pc[1] += cmd.start;
		pc[2] += cmd.irq_reset;
		pc[3] += cmd.tt_reset;
		pc[4] += cmd.tt_test_clk;
	end
	// ==========================================================
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test
	function automatic logic [7:0] ad(input logic [4:0] i);
		return {1'b0, i, 2'b00};
	endfunction : ad
	// Mode readback: engine bits overlaid, enhanced-only fields zero otherwise
	function automatic logic [15:0] exp_mode(input logic [15:0] m, input logic enh,
		input logic [4:0] a);
		case ({m[15:14], enh})
			3'b001: return {m[15:3], 1'b1, a[4], a[3]};
			3'b101: return {m[15:7], 6'h00, a[2]};
			3'b011: return {m[15:9], 1'b0, m[7], 4'h0, 1'b1, a[1], a[0]};
			default: return {m[15:12], 12'h000};
		endcase
	endfunction : exp_mode
	// Write: address and data offered together, each released once taken
	task automatic axw(input logic [7:0] a, input logic [15:0] x, output logic [1:0] rs);
		int n;
		logic aw_ok, w_ok, b_ok;
		n = 0;
		b_ok = 1'b0;
		rs = 2'b11;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, x};
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b_ok && n < 50)
		begin
			@(negedge clock);
			aw_ok = s_axi_awvalid && s_axi_awready;
			w_ok = s_axi_wvalid && s_axi_wready;
			b_ok = s_axi_bvalid && s_axi_bready;
			rs = s_axi_bresp;
			n++;
			@(posedge clock);
			if (aw_ok) s_axi_awvalid <= 1'b0;
			if (w_ok) s_axi_wvalid <= 1'b0;
			if (b_ok) s_axi_bready <= 1'b0;
		end
		if (!b_ok) err_count++;
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] x, output logic [1:0] rs);
		int n;
		logic ar_ok, r_ok;
		n = 0;
		r_ok = 1'b0;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!r_ok && n < 50)
		begin
			@(negedge clock);
			ar_ok = s_axi_arvalid && s_axi_arready;
			r_ok = s_axi_rvalid && s_axi_rready;
			x = s_axi_rdata;
			rs = s_axi_rresp;
			n++;
			@(posedge clock);
			if (ar_ok) s_axi_arvalid <= 1'b0;
			if (r_ok) s_axi_rready <= 1'b0;
		end
		if (!r_ok) err_count++;
	endtask : axr
	task automatic wr(input logic [4:0] i, input logic [15:0] x);
		logic [1:0] rs;
		axw(ad(i), x, rs);
	endtask : wr
	task automatic rd(input logic [4:0] i, output logic [31:0] x);
		logic [1:0] rs;
		axr(ad(i), x, rs);
	endtask : rd
	// One-cycle event pulse on the end-of-message bit; the caller checks once the status has landed
	task automatic evp;
		@(posedge clock);
		eng_events <= 16'h0001 << BTC_ST_EOM;
		@(posedge clock);
		eng_events <= 16'h0000;
	endtask : evp
	task automatic chk_irq(input logic e);
		@(negedge clock);
		check("irq", irq, e);
	endtask : chk_irq
	// ==========================================================
	// Watchdog sized well above the few hundred cycles the tests need
	initial
	begin
		#500000;
		err_count++;
		end_of_test();
	end
	initial
	begin
		{clock, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{eng_events, act, ptr} = '0;
		seed = 32'ha9df;
		repeat (8) @(posedge clock);
		rstn <= 1'b1;
		rd(BTC_IDX_MODE, v);
		check("mode reset", v, {16'h0, BTC_RST_MODE});
		rd(BTC_IDX_GCFG, v);
		check("gcfg reset", v, {16'h0, BTC_RST_GCFG});
		rd(BTC_IDX_MCW, v);
		check("mcw reset", v, {16'h0, BTC_RST_MCW});
		$display("test reset done");
		for (int i = 0; i < 4; i++)
		begin
			d = (i == 0) ? 16'hffff : 16'($random(seed));
			wr(BTC_IDX_GCFG, d);
			rd(BTC_IDX_GCFG, v);
			check("gcfg read", v, {16'h0, d});
			check("gcfg decode", {cfg.enh_irq, cfg.parity_en, cfg.busy_lut_en, cfg.rx_dbl_buf,
				cfg.ovwr_invalid, cfg.no_256_bound, cfg.tt_res, cfg.tt_clr_sync, cfg.tt_load_sync,
				cfg.clr_srq, cfg.enh_rt_mm, cfg.sep_bcst}, {d[15:5], d[2:0]});
			d = (i == 0) ? 16'hffff : 16'($random(seed));
			wr(BTC_IDX_MCW, d);
			rd(BTC_IDX_MCW, v);
			check("mcw read", v, {16'h0, d});
			check("mcw decode", {cfg.tx_tt_sync, cfg.mcw}, {d[15], d});
		end
		wr(BTC_IDX_GCFG, 16'h0000);
		$display("test config done");
		wr(BTC_IDX_CMD, 16'h0001 << BTC_CMD_START);
		for (int i = 0; i < 4; i++)
		begin
			fn = (i == 1) ? BTC_FN_RT : (i == 2) ? BTC_FN_MT : BTC_FN_BC;
			wr(BTC_IDX_ENH, (i < 3) ? 16'h8000 : 16'h0000);
			act <= 5'($random(seed));
			d = {fn, 14'($random(seed))};
			wr(BTC_IDX_MODE, d);
			rd(BTC_IDX_MODE, v);
			check("mode fn", cfg.fn, fn);
			check("mode read", v, {16'h0, exp_mode(d, i < 3, act)});
			check("mode ctl", cfg.mode_ctl, (i == 3) ? {d[15:12], 12'h000} : d);
			if (i == 1) check("alongside", cfg.mon_alongside, d[12]);
		end
		$display("test mode done");
		for (int b = 0; b < 7; b++)
		begin
			c = pc;
			d = (b < 5) ? 16'h0001 << b : (b == 5) ? 16'hffe0 : 16'h0000;
			wr(BTC_IDX_CMD, d);
			repeat (2) @(posedge clock);
			for (int k = 0; k < 5; k++) check("cmd pulse", pc[k] - c[k], k == b);
		end
		ptr <= 16'($random(seed));
		rd(BTC_IDX_CMD, v);
		check("stack ptr", v, {16'h0, ptr});
		$display("test command done");
		for (int i = 0; i < 4; i++)
		begin
			axw(bad[i], 16'hffff, r);
			check("bad wr resp", r, 2'b10);
			axr(bad[i], v, r);
			check("bad rd resp", r, 2'b10);
			check("bad rd data", v, 32'h0);
		end
		$display("test unmapped done");
		wr(BTC_IDX_IRQ_MASK, 16'h0001);
		evp();
		chk_irq(1'b1);
		rd(BTC_IDX_IRQ_STAT, v);
		check("status set", v, 32'h1);
		wr(BTC_IDX_IRQ_MASK, 16'h0000);
		chk_irq(1'b0);
		wr(BTC_IDX_IRQ_MASK, 16'h0001);
		chk_irq(1'b1);
		wr(BTC_IDX_IRQ_STAT, 16'h0001);
		chk_irq(1'b0);
		evp();
		wr(BTC_IDX_CMD, 16'h0001 << BTC_CMD_IRQRST);
		rd(BTC_IDX_IRQ_STAT, v);
		check("irq reset", v, 32'h0);
		wr(BTC_IDX_GCFG, 16'h0001 << BTC_GCFG_AUTOCLR);
		evp();
		rd(BTC_IDX_IRQ_STAT, v);
		rd(BTC_IDX_IRQ_STAT, v);
		check("auto clear", v, 32'h0);
		wr(BTC_IDX_GCFG, 16'h0001 << BTC_GCFG_PULSE);
		ic = irq_cnt;
		evp();
		repeat (4) @(posedge clock);
		check("pulse irq", irq_cnt - ic, 1);
		$display("test interrupt done");
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
